// [byte_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface byte_link_if;
   logic       rx_valid;
   logic [7:0] rx_data;
   logic       tx_valid;
   logic [7:0] tx_data;
   logic       tx_ready;
   modport core (input rx_valid, rx_data, tx_ready,
                 output tx_valid, tx_data);
   modport phy  (output rx_valid, rx_data, tx_ready,
                 input tx_valid, tx_data);
endinterface
`default_nettype wire

// [readout_cfg.svh]
`ifndef READOUT_CFG_SVH
`define READOUT_CFG_SVH

// ------------------------------------------------------------
// Command bytes
// ------------------------------------------------------------
`define CMD_PACKET_START 8'hAA
`define CMD_READ_FIRST   8'h81
`define CMD_READ_LAST    8'hBF
`define CMD_ERR_HALT     8'hB3
`define CMD_ERR_OCC      8'hB5

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS    25
`define MS_NS            1000000
`define PULSE_UNIT_NS    2000
`define PULSE_UNIT_DEN   3

// ------------------------------------------------------------
// Variable formation
// ------------------------------------------------------------
`define SPEED_OFFSET     32'sh0000_0800
`define VAR_MAX          12'hFFF
`define INT16_MAX        32'sh0000_7FFF

`endif

// [readout_pkg.sv]
package readout_pkg;

   typedef enum logic [1:0] {
      IN_SERIAL = 2'h0,
      IN_ANALOG = 2'h1,
      IN_PULSE  = 2'h2
   } in_mode_t;

   typedef enum logic {
      FB_NONE   = 1'b0,
      FB_ANALOG = 1'b1
   } fb_mode_t;

   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_ADDR = 2'b01,
      PS_CMD  = 2'b11
   } parse_t;

   typedef struct packed {
      logic        rx_prev;
      logic        rx_busy;
      logic [3:0]  rx_bit;
      logic [15:0] rx_cnt;
      logic [7:0]  rx_sh;
      logic        rx_valid;
      logic        tx_busy;
      logic [3:0]  tx_bit;
      logic [15:0] tx_cnt;
      logic [8:0]  tx_sh;
      logic        tx;
   } uart_st_t;

   typedef struct packed {
      parse_t             ps;
      logic               addr_ok;
      logic [15:0]        rword;
      logic [1:0]         rcnt;
      logic [11:0]        in_v;
      logic [11:0]        tgt;
      logic [11:0]        fb;
      logic [11:0]        sfb;
      logic signed [15:0] isum;
      logic signed [15:0] dtgt;
      logic signed [15:0] duty;
      logic signed [13:0] perr;
      logic [7:0]         cur;
      logic [15:0]        loops;
      logic [15:0]        ms_cnt;
      logic [7:0]         per_cnt;
      logic [7:0]         brk;
      logic               tick;
      logic               pin_q;
      logic               pw_run;
      logic [6:0]         pw_acc;
      logic [11:0]        pw_cnt;
   } core_st_t;

endpackage

// [serial_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_master_model #(
   parameter int BIT_CYCLES = 16
) (
   input  wire logic       clk,      // Bench clock.
   output var  logic       line_out, // Commands to the device.
   input  wire logic       line_in,  // Answers from the device.
   output var  logic       got_v,    // One-cycle byte strobe.
   output var  logic [7:0] got_d     // Received byte.
);
   initial begin
      line_out = 1'b1;
      got_v = 1'b0;
      got_d = 8'h00;
   end

   // --------------------------------------------------------------
   // Frame sender, 8N1, least significant bit first
   // --------------------------------------------------------------
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge clk);
      #2;
      for (int i = 0; i < 10; i++) begin
         line_out = f[i];
         repeat (BIT_CYCLES) @(posedge clk);
         #2;
      end
   endtask

   // --------------------------------------------------------------
   // Frame receiver; a byte with a low stop bit is dropped.
   // --------------------------------------------------------------
   initial begin : rx_loop
      logic [7:0] d;
      forever begin
         @(negedge line_in);
         repeat (BIT_CYCLES / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk);
            d[i] = line_in;
         end
         repeat (BIT_CYCLES) @(posedge clk);
         if (line_in === 1'b1) begin
            #2;
            got_d = d;
            got_v = 1'b1;
            @(posedge clk);
            #2;
            got_v = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [serial_variable_readout.sv]
// Functional notes
// RULE1 - Bare command or 0xAA, device, command packet.
// RULE2 - Two-byte reads send low byte first.
// RULE3 - Signed variables use two's complement.
// RULE4 - Low-byte read returns one low byte.
// RULE5 - High-byte read returns one high byte.
// RULE6 - Input variable codes; serial mode equals target.
// RULE7 - Analog input: 0 is 0V, 4092 5V.
// RULE8 - Pulse input counts two-thirds microsecond units.
// RULE9 - Target from serial or scaled input.
// RULE10 - Feedback analog measured; zero without feedback.
// RULE11 - Scaled feedback is feedback after scaling.
// RULE12 - Current reads zero without current limit.
// RULE13 - Integral adds scaled feedback minus target.
// RULE14 - Integral clears when idle, clamped, optional reset.
// RULE15 - Duty target: target-2048 or PID sum.
// RULE16 - Duty limited by accel, max, current, brake.
// RULE17 - Loop tick counter increments, wraps at 65535.
// RULE18 - Unlisted 0x81..0xBF still answer.
// RULE19 - Commands on rx, responses on tx.
// RULE20 - Transmit line idles high.
// RULE21 - Transmit only when addressed.
// RULE22 - Master keeps device numbers distinct.
// RULE23 - Mismatched address: no answer, no change.
`timescale 1ns/10ps
`default_nettype none
`include "readout_cfg.svh"
module serial_variable_readout #(
   parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
   input  wire logic                  clk,              // 40 MHz.
   input  wire logic                  arst_n,           // Reset, low.
   input  wire logic                  rx,               // Serial in.
   input  wire logic                  pulse_in,         // RC pulse.
   input  wire logic [9:0]            adc_rx,           // Rx pin ADC.
   input  wire logic [9:0]            adc_fb,           // Fb pin ADC.
   input  wire logic [7:0]            motor_current,    // Current ADC.
   input  wire logic [11:0]           serial_target,    // Set target.
   input  wire logic [6:0]            device_number,    // Own address.
   input  wire logic [15:0]           baud_div,         // Bit cycles-1.
   input  wire readout_pkg::in_mode_t input_mode,       // Input mode.
   input  wire readout_pkg::fb_mode_t feedback_mode,    // Fb mode.
   input  wire logic [8:0]            in_gain,          // 256 = unity.
   input  wire logic [8:0]            fb_gain,          // 256 = unity.
   input  wire logic [7:0]            kp,               // P gain /16.
   input  wire logic [7:0]            ki,               // I gain /256.
   input  wire logic [7:0]            kd,               // D gain /16.
   input  wire logic [7:0]            pid_period_ms,    // Loop period.
   input  wire logic [14:0]           integral_limit,   // Sum clamp.
   input  wire logic                  int_reset_en,     // P over reset.
   input  wire logic [9:0]            max_duty,         // Duty clamp.
   input  wire logic [9:0]            max_accel,        // 0 = no limit.
   input  wire logic                  current_limit_en, // Limit on.
   input  wire logic [7:0]            current_limit,    // Limit value.
   input  wire logic [7:0]            brake_ticks,      // Brake periods.
   input  wire logic                  motor_enable,     // Driving.
   output var  logic                  tx,               // Serial out.
   output var  logic [15:0]           duty_cycle        // Applied duty.
);
   import readout_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rs_ff;
   logic       rst_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rs_ff <= 2'b00;
      end else begin
         rs_ff <= {rs_ff[0], 1'b1};
      end
   end
   assign rst_n = rs_ff[1];

   // ------------------------------------------------------------
   // Serial line
   // ------------------------------------------------------------
   byte_link_if lnk ();

   uart_phy u_phy ( // [RULE19]
      .clk      (clk),
      .rst_n    (rst_n),
      .rx       (rx),
      .baud_div (baud_div),
      .tx       (tx),
      .lnk      (lnk)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   localparam logic [6:0] PW_MOD = 7'(`PULSE_UNIT_NS / `CLK_PERIOD_NS);
   localparam logic [6:0] PW_DEN = 7'(`PULSE_UNIT_DEN);

   function automatic logic [11:0] scale12(logic [11:0] v,
                                           logic [8:0] g);
      logic [20:0] m;
      m = 21'(v) * 21'(g);
      return (m[20:8] > 13'h0FFF) ? `VAR_MAX : m[19:8];
   endfunction

   function automatic int clamp(int v, int lim);
      return (v > lim) ? lim : ((v < -lim) ? -lim : v);
   endfunction

   function automatic logic [15:0] read_var(logic [3:0] i,
                                            core_st_t s);
      case (i)
         4'h0:    return {4'h0, s.in_v};
         4'h1:    return {4'h0, s.tgt};
         4'h2:    return {4'h0, s.fb};
         4'h3:    return {4'h0, s.sfb};
         4'h4:    return s.isum;
         4'h5:    return s.dtgt;
         4'h6:    return s.duty;
         4'h7:    return {8'h00, s.cur};
         4'h8:    return s.loops;
         default: return 16'h0000;
      endcase
   endfunction

   core_st_t    st_ff;
   core_st_t    nxt_st;
   logic        rd_go;
   logic [7:0]  rd_cmd;
   logic [15:0] var_word;

   assign lnk.tx_valid = (st_ff.rcnt != 2'h0);
   assign lnk.tx_data  = st_ff.rword[7:0];
   assign duty_cycle   = st_ff.duty;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      int e;
      int p;
      int it;
      int d;
      int a;
      int des;
      int step;
      logic go;
      e        = 0;
      p        = 0;
      it       = 0;
      d        = 0;
      a        = 0;
      des      = 0;
      step     = 0;
      go       = 1'b0;
      nxt_st   = st_ff;
      rd_cmd   = 8'h00;
      nxt_st.tick  = 1'b0;
      nxt_st.pin_q = pulse_in;

      // Loop period timing.
      if (st_ff.ms_cnt == 16'(MS_CYCLES - 1)) begin
         nxt_st.ms_cnt = 16'h0000;
         if (st_ff.per_cnt + 8'h01 >= pid_period_ms) begin
            nxt_st.per_cnt = 8'h00;
            nxt_st.tick    = 1'b1;
         end else begin
            nxt_st.per_cnt = st_ff.per_cnt + 8'h01;
         end
      end else begin
         nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
      end

      // Pulse width in 2/3 us units by fractional accumulation.
      if (pulse_in && !st_ff.pin_q) begin
         nxt_st.pw_run = 1'b1;
         nxt_st.pw_cnt = 12'h000;
         nxt_st.pw_acc = 7'h00;
      end else if (st_ff.pw_run) begin
         if (!pulse_in) begin
            nxt_st.pw_run = 1'b0;
         end else if (st_ff.pw_acc + PW_DEN >= PW_MOD) begin // [RULE8]
            nxt_st.pw_acc = st_ff.pw_acc + PW_DEN - PW_MOD;
            if (st_ff.pw_cnt != `VAR_MAX) begin
               nxt_st.pw_cnt = st_ff.pw_cnt + 12'h001;
            end
         end else begin
            nxt_st.pw_acc = st_ff.pw_acc + PW_DEN;
         end
      end

      // Measured variables.
      case (input_mode)
         IN_ANALOG: nxt_st.in_v = {adc_rx, 2'b00}; // [RULE7]
         IN_PULSE: begin
            if (st_ff.pw_run && !pulse_in) begin
               nxt_st.in_v = st_ff.pw_cnt; // [RULE8]
            end
         end
         default:   nxt_st.in_v = serial_target; // [RULE6]
      endcase
      nxt_st.tgt = (input_mode == IN_SERIAL) ? serial_target
                 : scale12(st_ff.in_v, in_gain); // [RULE9]
      nxt_st.fb  = (feedback_mode == FB_NONE) ? 12'h000
                 : {adc_fb, 2'b00}; // [RULE10]
      nxt_st.sfb = scale12(st_ff.fb, fb_gain); // [RULE11]
      nxt_st.cur = current_limit_en ? motor_current : 8'h00; // [RULE12]

      // Control loop, once per period.
      if (st_ff.tick) begin
         nxt_st.loops = st_ff.loops + 16'h0001; // [RULE17]
         e  = int'(st_ff.sfb) - int'(st_ff.tgt); // [RULE13]
         p  = (int'(kp) * e) >>> 4;
         it = (int'(ki) * int'(st_ff.isum)) >>> 8;
         d  = (int'(kd) * (e - int'(st_ff.perr))) >>> 4;
         nxt_st.perr = 14'(e);
         a = int'(st_ff.isum) + e; // [RULE13]
         if (int_reset_en && (p > int'(max_duty) ||
                              p < -int'(max_duty))) begin
            a = 0; // [RULE14]
         end
         nxt_st.isum = 16'(clamp(a, int'(integral_limit))); // [RULE14]
         if (feedback_mode == FB_NONE) begin
            a = int'(st_ff.tgt) - `SPEED_OFFSET; // [RULE15]
         end else begin
            a = clamp(p + it + d, `INT16_MAX); // [RULE15]
         end
         nxt_st.dtgt = 16'(a); // [RULE3]
         des = clamp(a, int'(max_duty)); // [RULE16]
         if (current_limit_en && st_ff.cur > current_limit) begin
            des = 0; // [RULE16]
         end
         if (st_ff.brk != 8'h00) begin
            nxt_st.duty = 16'sh0000;
            nxt_st.brk  = st_ff.brk - 8'h01;
         end else if ((st_ff.duty > 0 && des < 0) ||
                      (st_ff.duty < 0 && des > 0)) begin
            nxt_st.duty = 16'sh0000; // [RULE16]
            nxt_st.brk  = brake_ticks;
         end else begin
            step = des - int'(st_ff.duty);
            if (max_accel != 10'h000) begin
               step = clamp(step, int'(max_accel)); // [RULE16]
            end
            nxt_st.duty = 16'(int'(st_ff.duty) + step);
         end
      end
      if (!motor_enable) begin
         nxt_st.isum = 16'sh0000; // [RULE14]
         nxt_st.duty = 16'sh0000;
         nxt_st.brk  = 8'h00;
      end

      // Command parser.
      if (lnk.rx_valid) begin
         if (lnk.rx_data[7]) begin
            nxt_st.ps = PS_IDLE;
            if (lnk.rx_data == `CMD_PACKET_START) begin
               nxt_st.ps = PS_ADDR; // [RULE1]
            end else begin
               go     = 1'b1; // [RULE1]
               rd_cmd = lnk.rx_data;
            end
         end else begin
            case (st_ff.ps)
               PS_ADDR: begin
                  // Distinct addresses keep answers apart.
                  nxt_st.addr_ok = (lnk.rx_data[6:0] == device_number); // [RULE22]
                  nxt_st.ps      = PS_CMD;
               end
               PS_CMD: begin
                  go        = st_ff.addr_ok; // [RULE21] [RULE23]
                  rd_cmd    = {1'b1, lnk.rx_data[6:0]}; // [RULE1]
                  nxt_st.ps = PS_IDLE;
               end
               default: nxt_st.ps = PS_IDLE;
            endcase
         end
      end
      rd_go = go && rd_cmd >= `CMD_READ_FIRST &&
              rd_cmd <= `CMD_READ_LAST && // [RULE18]
              rd_cmd != `CMD_ERR_HALT && rd_cmd != `CMD_ERR_OCC;
      var_word = read_var(4'((rd_cmd[4:0] - 5'h01) >> 1), st_ff);

      // Response byte queue.
      if (rd_go) begin
         if (rd_cmd[5]) begin
            nxt_st.rword = var_word; // [RULE2]
            nxt_st.rcnt  = 2'h2;
         end else begin
            nxt_st.rword = {8'h00, rd_cmd[0] ? var_word[7:0] // [RULE4]
                                             : var_word[15:8]}; // [RULE5]
            nxt_st.rcnt  = 2'h1;
         end
      end else if (st_ff.rcnt != 2'h0 && lnk.tx_ready) begin
         nxt_st.rword = {8'h00, st_ff.rword[15:8]}; // [RULE2]
         nxt_st.rcnt  = st_ff.rcnt - 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   two_byte_load_a: assert property ( // [RULE2]
      rd_go && rd_cmd[5] |=> st_ff.rcnt == 2'h2 &&
         st_ff.rword == $past(var_word))
      else $error("two-byte answer not queued");
   lsb_first_a: assert property ( // [RULE2]
      st_ff.rcnt == 2'h2 && lnk.tx_ready |=>
         lnk.tx_data == $past(st_ff.rword[15:8]))
      else $error("high byte not second");
   low_byte_a: assert property ( // [RULE4]
      rd_go && !rd_cmd[5] && rd_cmd[0] |=> st_ff.rcnt == 2'h1 &&
         lnk.tx_data == $past(var_word[7:0]))
      else $error("low byte answer wrong");
   high_byte_a: assert property ( // [RULE5]
      rd_go && !rd_cmd[5] && !rd_cmd[0] |=> st_ff.rcnt == 2'h1 &&
         lnk.tx_data == $past(var_word[15:8]))
      else $error("high byte answer wrong");
   undoc_read_a: assert property ( // [RULE18]
      lnk.rx_valid && lnk.rx_data inside {[8'h93:8'hA0]}
         |=> st_ff.rcnt != 2'h0)
      else $error("undocumented read gave no answer");
   addr_miss_a: assert property ( // [RULE23]
      lnk.rx_valid && st_ff.ps == PS_CMD && !st_ff.addr_ok &&
         !lnk.rx_data[7] |=> st_ff.rcnt <= $past(st_ff.rcnt))
      else $error("answer to foreign address");
   analog_in_a: assert property ( // [RULE7]
      input_mode == IN_ANALOG |=> st_ff.in_v == {$past(adc_rx), 2'b00})
      else $error("analog input misscaled");
   fb_none_a: assert property ( // [RULE10]
      feedback_mode == FB_NONE |=> st_ff.fb == 12'h000)
      else $error("feedback not zero");
   cur_zero_a: assert property ( // [RULE12]
      !current_limit_en |=> st_ff.cur == 8'h00)
      else $error("current not zero");
   isum_clear_a: assert property ( // [RULE14]
      !motor_enable |=> st_ff.isum == 16'sh0000)
      else $error("integral not cleared");
   speed_dtgt_a: assert property ( // [RULE15]
      st_ff.tick && feedback_mode == FB_NONE |=>
         st_ff.dtgt == 16'($past(int'(st_ff.tgt)) - `SPEED_OFFSET))
      else $error("speed duty target wrong");
   loop_wrap_a: assert property ( // [RULE17]
      st_ff.tick |=> st_ff.loops == $past(st_ff.loops) + 16'h0001)
      else $error("loop counter step wrong");

endmodule
`default_nettype wire

// [serial_variable_readout_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_variable_readout_tb;
   import readout_pkg::*;
   logic        clk, arst_n, rx, tx, pulse_in, cur_en, mot_en, got_v;
   logic [9:0]  adc_rx, adc_fb;
   logic [7:0]  mcur, got_d;
   logic [11:0] tgt;
   logic [6:0]  dev;
   logic [15:0] duty;
   in_mode_t    imode;
   fb_mode_t    fmode;
   logic [7:0]  exp_q[$];
   int          err_total, checks_done, cyc;
   logic [15:0] bdiv;
   logic [14:0] ilim;
   logic [9:0]  mduty, macc;
   logic [8:0]  ing, fbg;
   logic [7:0]  kp, ki, kd, per, clim, brk;
   logic        irst;

   serial_variable_readout #(.MS_CYCLES(40)) serial_variable_readout_i (
      .clk(clk), .arst_n(arst_n), .rx(rx), .pulse_in(pulse_in),
      .adc_rx(adc_rx), .adc_fb(adc_fb), .motor_current(mcur),
      .serial_target(tgt), .device_number(dev), .baud_div(bdiv),
      .input_mode(imode), .feedback_mode(fmode), .in_gain(ing),
      .fb_gain(fbg), .kp(kp), .ki(ki), .kd(kd),
      .pid_period_ms(per), .integral_limit(ilim),
      .int_reset_en(irst), .max_duty(mduty), .max_accel(macc),
      .current_limit_en(cur_en), .current_limit(clim),
      .brake_ticks(brk), .motor_enable(mot_en), .tx(tx),
      .duty_cycle(duty));

   serial_master_model #(.BIT_CYCLES(16)) serial_master_model_i (
      .clk(clk), .line_out(rx), .line_in(tx), .got_v(got_v),
      .got_d(got_d));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // --------------------------------------------------------------
   // Reporting
   // --------------------------------------------------------------
   task fail(input string m);
      err_total++;
      $display("ERROR %0t: %s", $time, m);
   endtask

   task report_and_stop;
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // --------------------------------------------------------------
   // Answer checker and hang limit
   // --------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail("run timed out");
         report_and_stop;
      end
      if (got_v === 1'b1) begin
         checks_done++;
         if (exp_q.size() == 0)
            fail("unexpected answer byte");
         else begin
            if (got_d !== exp_q[0])
               fail("answer byte mismatch");
            void'(exp_q.pop_front());
         end
      end
   end

   // Sends one command byte and expects n answer bytes, low byte first.
   task automatic rd(input logic [7:0] c, input int n,
                     input logic [15:0] v);
      int k;
      if (n > 0) exp_q.push_back(v[7:0]);
      if (n > 1) exp_q.push_back(v[15:8]);
      serial_master_model_i.send(c);
      k = 0;
      while (exp_q.size() > 0 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      if (exp_q.size() > 0) begin
         fail("answer missing");
         exp_q.delete();
      end
      repeat (400) @(posedge clk);
      #2;
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      err_total = 0;
      checks_done = 0;
      arst_n = 1'b0;
      pulse_in = 1'b0;
      cur_en = 1'b0;
      mot_en = 1'b0;
      imode = IN_SERIAL;
      fmode = FB_NONE;
      bdiv = 16'h000F;
      ing = 9'h100;
      fbg = 9'h100;
      kp = 8'h10;
      ki = 8'h00;
      kd = 8'h00;
      per = 8'h01;
      ilim = 15'h7FFF;
      irst = 1'b0;
      mduty = 10'h258;
      macc = 10'h000;
      clim = 8'hFF;
      brk = 8'h00;
      void'($urandom(32'h0C5C));
      dev = 7'($urandom);
      tgt = 12'($urandom);
      adc_rx = 10'($urandom);
      adc_fb = 10'($urandom);
      mcur = 8'($urandom);
      repeat (3) @(posedge clk);
      #2;
      arst_n = 1'b1;
      repeat (6) @(posedge clk);
      #2;
      checks_done++;
      if (tx !== 1'b1) fail("transmit line not idle high");
      rd(8'hA3, 2, {4'h0, tgt});
      rd(8'h83, 1, {8'h00, tgt[7:0]});
      rd(8'h84, 1, {12'h000, tgt[11:8]});
      rd(8'hA1, 2, {4'h0, tgt});
      rd(8'hA5, 2, 16'h0000);
      rd(8'h89, 1, 16'h0000);
      rd(8'hBD, 2, 16'h0000);
      rd(8'h93, 1, 16'h0000);
      rd(8'hB3, 0, 16'h0000);
      serial_master_model_i.send(8'hAA);
      serial_master_model_i.send({1'b0, dev});
      rd(8'h23, 2, {4'h0, tgt});
      serial_master_model_i.send(8'hAA);
      serial_master_model_i.send({1'b0, dev ^ 7'h01});
      rd(8'h23, 0, 16'h0000);
      rd(8'h8F, 1, 16'h0000);
      cur_en = 1'b1;
      rd(8'h8F, 1, {8'h00, mcur});
      fmode = FB_ANALOG;
      rd(8'hA5, 2, {4'h0, adc_fb, 2'b00});
      rd(8'hA7, 2, {4'h0, adc_fb, 2'b00});
      imode = IN_ANALOG;
      rd(8'hA1, 2, {4'h0, adc_rx, 2'b00});
      rd(8'hA3, 2, {4'h0, adc_rx, 2'b00});
      // A pulse of about 20 us reads as 30 units of two thirds of a us.
      imode = IN_PULSE;
      pulse_in = 1'b1;
      repeat (801) @(posedge clk);
      #2;
      pulse_in = 1'b0;
      rd(8'hA1, 2, 16'h001E);
      imode = IN_SERIAL;
      fmode = FB_NONE;
      tgt = 12'h7FE;
      mot_en = 1'b1;
      repeat (200) @(posedge clk);
      #2;
      checks_done++;
      if (duty !== 16'hFFFE) fail("applied duty wrong");
      rd(8'hAB, 2, 16'hFFFE);
      tgt = 12'h000;
      repeat (200) @(posedge clk);
      #2;
      checks_done++;
      if (duty !== 16'hFDA8) fail("duty not held to limit");
      rd(8'hAB, 2, 16'hF800);
      report_and_stop;
   end
endmodule
`default_nettype wire

// [uart_phy.sv]
`timescale 1ns/10ps
`default_nettype none
module uart_phy
   import readout_pkg::*;
(
   input  wire logic        clk,      // System clock.
   input  wire logic        rst_n,    // Synchronised reset, low.
   input  wire logic        rx,       // Serial receive line.
   input  wire logic [15:0] baud_div, // Cycles per bit minus one.
   output var  logic        tx,       // Serial transmit line.
   byte_link_if.phy         lnk       // Byte side.
);

   uart_st_t st_ff;
   uart_st_t nxt_st;

   assign lnk.rx_valid = st_ff.rx_valid;
   assign lnk.rx_data  = st_ff.rx_sh;
   assign lnk.tx_ready = !st_ff.tx_busy;
   assign tx           = st_ff.tx;

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.rx_valid = 1'b0;
      nxt_st.rx_prev  = rx;
      if (!st_ff.rx_busy) begin
         if (st_ff.rx_prev && !rx) begin
            nxt_st.rx_busy = 1'b1;
            nxt_st.rx_bit  = 4'h0;
            nxt_st.rx_cnt  = {1'b0, baud_div[15:1]};
         end
      end else if (st_ff.rx_cnt != 16'h0000) begin
         nxt_st.rx_cnt = st_ff.rx_cnt - 16'h0001;
      end else begin
         nxt_st.rx_cnt = baud_div;
         nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
         if (st_ff.rx_bit == 4'h0) begin
            nxt_st.rx_busy = !rx;
         end else if (st_ff.rx_bit < 4'h9) begin
            nxt_st.rx_sh = {rx, st_ff.rx_sh[7:1]};
         end else begin
            nxt_st.rx_busy  = 1'b0;
            nxt_st.rx_valid = rx;
         end
      end
      if (!st_ff.tx_busy) begin
         if (lnk.tx_valid) begin
            nxt_st.tx_busy = 1'b1;
            nxt_st.tx_sh   = {lnk.tx_data, 1'b0};
            nxt_st.tx_bit  = 4'h0;
            nxt_st.tx_cnt  = baud_div;
         end
      end else if (st_ff.tx_cnt != 16'h0000) begin
         nxt_st.tx_cnt = st_ff.tx_cnt - 16'h0001;
      end else begin
         nxt_st.tx_cnt = baud_div;
         nxt_st.tx_sh  = {1'b1, st_ff.tx_sh[8:1]};
         nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
         if (st_ff.tx_bit == 4'h9) begin
            nxt_st.tx_busy = 1'b0;
         end
      end
      // Line rests high between bytes.
      nxt_st.tx = nxt_st.tx_busy ? nxt_st.tx_sh[0] : 1'b1; // [RULE20]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff    <= '0;
         st_ff.tx <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   tx_idle_high_a: assert property ( // [RULE20]
      !st_ff.tx_busy |-> tx)
      else $error("tx not high while idle");
   tx_start_bit_a: assert property (
      !st_ff.tx_busy && lnk.tx_valid |=> !tx && st_ff.tx_busy)
      else $error("start bit missing");

endmodule
`default_nettype wire
